/* include/tmoc_pkg.sv */
package tmoc_pkg;
   // register byte offsets (32-bit words, APB)
   localparam logic [7:0] TMOC_OFF_CTL2 = 8'h04;
   localparam logic [7:0] TMOC_OFF_SMCFG = 8'h08;
   localparam logic [7:0] TMOC_OFF_CTL = 8'h20;
   localparam logic [7:0] TMOC_OFF_CHEN = 8'h24;
   localparam logic [7:0] TMOC_OFF_EVENT = 8'h28;
   localparam logic [7:0] TMOC_OFF_STAT = 8'h2C;
   localparam logic [7:0] TMOC_OFF_IRQEN = 8'h30;
   localparam logic [7:0] TMOC_OFF_IRQCLR = 8'h34;
   // timer_control_two field positions
   localparam int TMOC_B_SHADOW = 0;
   localparam int TMOC_B_CUC = 2;
   localparam int TMOC_B_DMA_SOURCE_SELECT = 3;
   localparam int TMOC_B_MM_LO = 4;
   localparam int TMOC_B_TIS = 7;
   localparam int TMOC_B_IDLE_LO = 8;
   localparam int TMOC_IDLE_W = 7;
   // writable mask of timer_control_two; bits 31:15 and 1 reserved
   localparam logic [31:0] TMOC_CTL2_MASK = 32'h00007FFD;
   localparam logic [31:0] TMOC_CTL2_RST = 32'h00000000;
   localparam logic [31:0] TMOC_SMCFG_MASK = 32'h0000FFF7;
   localparam logic [31:0] TMOC_SMCFG_RST = 32'h00000000;
   // own control register: bit0 counter enable, 1 update disable,
   // 2 update source, 3 primary output enable, 5:4 protection level
   localparam int TMOC_B_CEN = 0;
   localparam int TMOC_B_UDIS = 1;
   localparam int TMOC_B_USRC = 2;
   localparam int TMOC_B_POE = 3;
   localparam int TMOC_B_PROTECTION_LEVEL = 4;
   // event register: bit0 update generation, bit1 commutation generation
   localparam int TMOC_B_UG = 0;
   localparam int TMOC_B_CG = 1;
   localparam logic [1:0] TMOC_PROTECTION_LEVEL_OPEN = 2'h0;
   localparam int TMOC_NSTAT = 3;
   // sticky event bits
   localparam int TMOC_S_TRG = 0;
   localparam int TMOC_S_UPD = 1;
   localparam int TMOC_S_COM = 2;
   // width in bits of the dead time count, which is in timer clock cycles
   localparam int TMOC_DEAD_W = 8;

   typedef enum logic [2:0] {
      TMOC_MM_RESET = 3'b000,
      TMOC_MM_START = 3'b001,
      TMOC_MM_UPDATE = 3'b010,
      TMOC_MM_CC0 = 3'b011,
      TMOC_MM_REF0 = 3'b100,
      TMOC_MM_REF1 = 3'b101,
      TMOC_MM_REF2 = 3'b110,
      TMOC_MM_REF3 = 3'b111
   } tmoc_mm_type;

   // core timer events seen by the block
   typedef struct packed {
      logic overflow;
      logic restart;
      logic trig_pause;
      logic [3:0] cc_event;
      logic [3:0] ref_event;
   } tmoc_evt_type;

   // active channel levels from the compare logic
   typedef struct packed {
      logic [3:0] main;
      logic [2:0] comp;
   } tmoc_lvl_type;
endpackage

/* rtl/tmoc_dead_delay.sv */
`timescale 1ns/10ps
module tmoc_dead_delay #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // control
   input wire logic [W-1:0] dead_in,
   input wire logic level_in,
   // delayed level
   output logic level_out
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic out_q;
   logic out_d;
   wire differs = level_in != out_q;
   wire done = cnt_q >= dead_in;

   // a change is passed on only after it has held for the dead time
   always_comb begin
      cnt_d = '0;
      out_d = out_q;
      if (differs && done) begin
         out_d = level_in;
      end else if (differs) begin
         cnt_d = cnt_q + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_q <= '0;
         out_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         out_q <= out_d;
      end
   end

   assign level_out = out_q;
endmodule

/* rtl/tmoc_top.sv */
`timescale 1ns/10ps
// Overview of operation
// - output disabled: ch0 main shows idle bit
// - output disabled: ch0 comp shows idle bit
// - same idle levels for ch1, ch2; ch3 main only
// - idle bits writable only at protection 00
// - main idle change waits dead time on ch0-ch2
// - trigger input: pin0 or xor pins
// - mode 000: pulse on counter reset
// - mode 001: pulse on counter start
// - mode 010: pulse on update event
// - mode 011: pulse on ch0 capture/compare
// - modes 100-111: pulse on reference compare
// - dma request on channel or update
// - shadowed enables load at commutation
// - commutation by bit, optionally trigger edge
// - shadowing ignored without complementary output
// - update event sources unless disabled
module tmoc_top
   import tmoc_pkg::*;
#(
   parameter int DEAD_W = TMOC_DEAD_W
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // timer core
   input wire logic [2:0] chan_pin_in,
   input wire tmoc_pkg::tmoc_evt_type evt_in,
   input wire tmoc_pkg::tmoc_lvl_type lvl_in,
   input wire logic [DEAD_W-1:0] dead_time_in,
   // outputs
   output logic [3:0] chan_main_out,
   output logic [2:0] chan_comp_out,
   output logic master_trigger_out,
   output logic [3:0] dma_req_out,
   output logic trigger_input_out,
   output logic irq_out
);
   import tmoc_pkg::*;

   logic [31:0] ctl2_q;
   logic [31:0] ctl2_d;
   logic [31:0] smcfg_q;
   logic [5:0] ctl_q;
   logic [5:0] ctl_d;
   logic [6:0] chen_pre_q;
   logic [6:0] chen_q;
   logic [6:0] chen_d;
   logic [TMOC_NSTAT-1:0] stat_q;
   logic [TMOC_NSTAT-1:0] stat_d;
   logic [TMOC_NSTAT-1:0] irqen_q;
   logic trg_q;
   logic trg_d;
   logic [3:0] dma_q;
   logic tin_q;
   logic [3:0] main_q;
   logic [2:0] comp_q;
   logic [3:0] main_d;
   logic [2:0] comp_d;
   logic [2:0] main_dly;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = a == off;
   endfunction

   // bus decode
   wire acc = psel_in && penable_in;
   wire wr = acc && pwrite_in;
   wire sel_ctl2 = hit(paddr_in, TMOC_OFF_CTL2);
   wire sel_smcfg = hit(paddr_in, TMOC_OFF_SMCFG);
   wire sel_ctl = hit(paddr_in, TMOC_OFF_CTL);
   wire sel_chen = hit(paddr_in, TMOC_OFF_CHEN);
   wire sel_evt = hit(paddr_in, TMOC_OFF_EVENT);
   wire sel_stat = hit(paddr_in, TMOC_OFF_STAT);
   wire sel_irqen = hit(paddr_in, TMOC_OFF_IRQEN);
   wire sel_irqclr = hit(paddr_in, TMOC_OFF_IRQCLR);
   wire mapped = sel_ctl2 || sel_smcfg || sel_ctl || sel_chen || sel_evt || sel_stat
      || sel_irqen || sel_irqclr;

   // control fields
   wire shadow_en = ctl2_q[TMOC_B_SHADOW];
   wire cuc = ctl2_q[TMOC_B_CUC];
   wire dma_source_select = ctl2_q[TMOC_B_DMA_SOURCE_SELECT];
   wire tis = ctl2_q[TMOC_B_TIS];
   wire [2:0] mm = ctl2_q[TMOC_B_MM_LO +: 3];
   wire [6:0] idle = ctl2_q[TMOC_B_IDLE_LO +: TMOC_IDLE_W];
   wire poe = ctl_q[TMOC_B_POE];
   wire [1:0] protection_level = ctl_q[TMOC_B_PROTECTION_LEVEL +: 2];
   wire upd_dis = ctl_q[TMOC_B_UDIS];
   wire upd_src = ctl_q[TMOC_B_USRC];

   // event strobes from software
   wire ug_wr = wr && sel_evt && pwdata_in[TMOC_B_UG];
   wire cg_wr = wr && sel_evt && pwdata_in[TMOC_B_CG];
   wire cen_set = wr && sel_ctl && pwdata_in[TMOC_B_CEN] && !ctl_q[TMOC_B_CEN];

   // trigger input select and edge
   wire tin = tis ? ^chan_pin_in : chan_pin_in[0];
   wire tin_rise = tin && !tin_q;

   // update event sources; source bit restricts to over/underflow
   wire upd_evt = !upd_dis && (evt_in.overflow
      || (!upd_src && (ug_wr || evt_in.restart)));
   wire cnt_reset = ug_wr || evt_in.restart || evt_in.overflow;
   wire cnt_start = cen_set || evt_in.trig_pause;
   wire com_evt = cg_wr || (cuc && tin_rise);

   // trigger output source
   always_comb begin
      case (tmoc_mm_type'(mm))
         TMOC_MM_RESET: trg_d = cnt_reset;
         TMOC_MM_START: trg_d = cnt_start;
         TMOC_MM_UPDATE: trg_d = upd_evt;
         TMOC_MM_CC0: trg_d = evt_in.cc_event[0];
         TMOC_MM_REF0: trg_d = evt_in.ref_event[0];
         TMOC_MM_REF1: trg_d = evt_in.ref_event[1];
         TMOC_MM_REF2: trg_d = evt_in.ref_event[2];
         default: trg_d = evt_in.ref_event[3];
      endcase
   end

   // control register two write; idle bits locked unless open protection
   wire [31:0] ctl2_wmask = (protection_level == TMOC_PROTECTION_LEVEL_OPEN) ? TMOC_CTL2_MASK
      : (TMOC_CTL2_MASK & ~(32'h0000007F << TMOC_B_IDLE_LO));
   assign ctl2_d = (wr && sel_ctl2) ? ((ctl2_q & ~ctl2_wmask) | (pwdata_in & ctl2_wmask))
      : ctl2_q;
   assign ctl_d = (wr && sel_ctl) ? pwdata_in[5:0] : ctl_q;

   // channel enables: bits 3:0 main, 6:4 comp; ch3 has no complement
   always_comb begin
      chen_d = chen_q;
      if (!shadow_en && wr && sel_chen) begin
         chen_d = pwdata_in[6:0];
      end else if (shadow_en) begin
         chen_d[3] = chen_pre_q[3];
         if (!(wr && sel_chen)) begin
            chen_d[3] = chen_q[3];
         end else begin
            chen_d[3] = pwdata_in[3];
         end
         if (com_evt) begin
            chen_d[2:0] = chen_pre_q[2:0];
            chen_d[6:4] = chen_pre_q[6:4];
         end
      end
   end

   // status: set wins over clear
   wire [TMOC_NSTAT-1:0] stat_set = {com_evt && shadow_en, upd_evt, trg_d};
   wire [TMOC_NSTAT-1:0] stat_clr = (wr && sel_irqclr) ? pwdata_in[TMOC_NSTAT-1:0] : '0;
   assign stat_d = (stat_q & ~stat_clr) | stat_set;

   // output levels
   wire [3:0] main_idle = {idle[6], idle[4], idle[2], idle[0]};
   wire [2:0] comp_idle = {idle[5], idle[3], idle[1]};
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         main_d[i] = poe ? (lvl_in.main[i] & chen_q[i]) : main_idle[i];
      end
      for (int i = 0; i < 3; i++) begin
         comp_d[i] = poe ? (lvl_in.comp[i] & chen_q[4+i]) : comp_idle[i];
      end
   end

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_dead
         tmoc_dead_delay #(.W(DEAD_W)) u_dead (
            .ref_clk_in(ref_clk_in),
            .rst_in(rst_in),
            .dead_in(dead_time_in),
            .level_in(main_d[g]),
            .level_out(main_dly[g])
         );
      end
   endgenerate

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctl2_q <= TMOC_CTL2_RST;
         ctl_q <= '0;
         stat_q <= '0;
         trg_q <= 1'b0;
         tin_q <= 1'b0;
      end else begin
         ctl2_q <= ctl2_d;
         ctl_q <= ctl_d;
         stat_q <= stat_d;
         trg_q <= trg_d;
         tin_q <= tin;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         smcfg_q <= TMOC_SMCFG_RST;
         irqen_q <= '0;
         chen_pre_q <= '0;
         chen_q <= '0;
      end else begin
         if (wr && sel_smcfg) smcfg_q <= pwdata_in & TMOC_SMCFG_MASK;
         if (wr && sel_irqen) irqen_q <= pwdata_in[TMOC_NSTAT-1:0];
         if (wr && sel_chen) chen_pre_q <= pwdata_in[6:0];
         chen_q <= chen_d;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         dma_q <= '0;
         main_q <= '0;
         comp_q <= '0;
      end else begin
         dma_q <= dma_source_select ? {4{upd_evt}} : evt_in.cc_event;
         main_q <= {main_d[3], main_dly};
         comp_q <= comp_d;
      end
   end

   // read mux
   wire [31:0] rd = sel_ctl2 ? ctl2_q
      : sel_smcfg ? smcfg_q
      : sel_ctl ? {26'h0, ctl_q}
      : sel_chen ? {25'h0, chen_q}
      : sel_stat ? {29'h0, stat_q}
      : sel_irqen ? {29'h0, irqen_q}
      : 32'h00000000;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         prdata_out <= '0;
      end else if (psel_in && !penable_in && !pwrite_in) begin
         prdata_out <= rd;
      end
   end

   assign pready_out = 1'b1;
   assign pslverr_out = acc && !mapped;
   assign chan_main_out = main_q;
   assign chan_comp_out = comp_q;
   assign master_trigger_out = trg_q;
   assign dma_req_out = dma_q;
   assign trigger_input_out = tin_q;
   assign irq_out = |(stat_q & irqen_q);

   // assertions
   property p_idle3;
      @(posedge ref_clk_in) disable iff (rst_in) !poe |=> chan_main_out[3] == $past(idle[6]);
   endproperty
   a_idle3: assert property (p_idle3) else $error("ch3 idle level wrong");
   property p_idle0_comp;
      @(posedge ref_clk_in) disable iff (rst_in) !poe |=> chan_comp_out[0] == $past(idle[1]);
   endproperty
   a_idle0_comp: assert property (p_idle0_comp) else $error("ch0 comp idle wrong");
   property p_protection_level;
      @(posedge ref_clk_in) disable iff (rst_in)
         (wr && sel_ctl2 && protection_level != TMOC_PROTECTION_LEVEL_OPEN) |=> $stable(idle);
   endproperty
   a_protection_level: assert property (p_protection_level) else $error("idle bits changed while locked");
   property p_trg_pulse;
      @(posedge ref_clk_in) disable iff (rst_in)
         (mm == 3'b010 && $past(mm) == 3'b010 && $past(upd_evt)) |-> master_trigger_out;
   endproperty
   a_trg_pulse: assert property (p_trg_pulse) else $error("update trigger missing");
   property p_trg_reset;
      @(posedge ref_clk_in) disable iff (rst_in) (mm == 3'b000 && ug_wr) |=> master_trigger_out;
   endproperty
   a_trg_reset: assert property (p_trg_reset) else $error("reset trigger missing");
   property p_trg_ref;
      @(posedge ref_clk_in) disable iff (rst_in)
         (mm == 3'b101) |=> master_trigger_out == $past(evt_in.ref_event[1]);
   endproperty
   a_trg_ref: assert property (p_trg_ref) else $error("ref trigger wrong");
   property p_tin;
      @(posedge ref_clk_in) disable iff (rst_in)
         tis |=> trigger_input_out == ^$past(chan_pin_in);
   endproperty
   a_tin: assert property (p_tin) else $error("xor trigger input wrong");
   property p_dma;
      @(posedge ref_clk_in) disable iff (rst_in) (dma_source_select && upd_evt) |=> dma_req_out == 4'hF;
   endproperty
   a_dma: assert property (p_dma) else $error("dma on update missing");
   property p_upd_dis;
      @(posedge ref_clk_in) disable iff (rst_in) upd_dis |-> !upd_evt;
   endproperty
   a_upd_dis: assert property (p_upd_dis) else $error("update while disabled");
   property p_shadow;
      @(posedge ref_clk_in) disable iff (rst_in)
         (shadow_en && !com_evt) |=> chen_q[2:0] == $past(chen_q[2:0]);
   endproperty
   a_shadow: assert property (p_shadow) else $error("shadow loaded early");
   property p_trg_start;
      @(posedge ref_clk_in) disable iff (rst_in)
         (mm == 3'b001 && cen_set) |=> master_trigger_out;
   endproperty
   a_trg_start: assert property (p_trg_start) else $error("start trigger missing");
   property p_trg_cc0;
      @(posedge ref_clk_in) disable iff (rst_in)
         (mm == 3'b011) |=> master_trigger_out == $past(evt_in.cc_event[0]);
   endproperty
   a_trg_cc0: assert property (p_trg_cc0) else $error("cc0 trigger wrong");
   property p_tin_pin;
      @(posedge ref_clk_in) disable iff (rst_in)
         !tis |=> trigger_input_out == $past(chan_pin_in[0]);
   endproperty
   a_tin_pin: assert property (p_tin_pin) else $error("pin trigger input wrong");
   property p_dma_cc;
      @(posedge ref_clk_in) disable iff (rst_in)
         !dma_source_select |=> dma_req_out == $past(evt_in.cc_event);
   endproperty
   a_dma_cc: assert property (p_dma_cc) else $error("dma on capture wrong");
   property p_com_edge;
      @(posedge ref_clk_in) disable iff (rst_in)
         (shadow_en && cuc && tin_rise) |=> chen_q[2:0] == $past(chen_pre_q[2:0]);
   endproperty
   a_com_edge: assert property (p_com_edge) else $error("edge commutation missing");
   property p_ch3_direct;
      @(posedge ref_clk_in) disable iff (rst_in)
         (shadow_en && wr && sel_chen) |=> chen_q[3] == $past(pwdata_in[3]);
   endproperty
   a_ch3_direct: assert property (p_ch3_direct) else $error("ch3 enable shadowed");
   property p_upd_src;
      @(posedge ref_clk_in) disable iff (rst_in)
         (upd_src && !evt_in.overflow) |-> !upd_evt;
   endproperty
   a_upd_src: assert property (p_upd_src) else $error("restricted update source");
   c_trg: cover property (@(posedge ref_clk_in) master_trigger_out);
   c_com: cover property (@(posedge ref_clk_in) shadow_en && com_evt);
   c_irq: cover property (@(posedge ref_clk_in) irq_out);
   c_dead: cover property (@(posedge ref_clk_in) main_dly[0] != main_d[0]);
   c_lock: cover property (@(posedge ref_clk_in) wr && sel_ctl2 && protection_level != TMOC_PROTECTION_LEVEL_OPEN);
endmodule

/* sim/tmoc_slave_model.sv */
`timescale 1ns/10ps
module tmoc_slave_model (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // trigger from master
   input wire logic trig_in,
   // observations
   output logic [15:0] pulse_count_out,
   output logic long_pulse_out
);
   logic trig_q;
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         trig_q <= 1'b0;
         pulse_count_out <= 16'h0000;
         long_pulse_out <= 1'b0;
      end else begin
         trig_q <= trig_in;
         if (trig_in && !trig_q) pulse_count_out <= pulse_count_out + 16'h0001;
         if (trig_in && trig_q) long_pulse_out <= 1'b1;
      end
   end
endmodule

/* sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
   import tmoc_pkg::*;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, mtrig, trig_in, irq, long_pulse;
   logic [2:0] pins = 3'h0;
   logic [2:0] comp;
   logic [3:0] main, dma;
   logic [15:0] cnt;
   tmoc_evt_type evt = '0;
   tmoc_lvl_type lvl = '0;
   int fail_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   int seed = 32'h19F11A15;
   logic last_err;
   logic [31:0] q;
   logic [31:0] r;
   logic [7:0] dead = 8'h03;
   logic [15:0] base;
   logic [3:0] seen;
   logic [6:0] v;
   logic sel;
   tmoc_evt_type e;

   tmoc_top #(.DEAD_W(8)) dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .chan_pin_in(pins), .evt_in(evt), .lvl_in(lvl),
      .dead_time_in(dead), .chan_main_out(main), .chan_comp_out(comp),
      .master_trigger_out(mtrig), .dma_req_out(dma), .trigger_input_out(trig_in),
      .irq_out(irq));
   tmoc_slave_model slave_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .trig_in(mtrig), .pulse_count_out(cnt), .long_pulse_out(long_pulse));

   always #25 ref_clk_in = ~ref_clk_in;
   // idle levels must not follow the active levels
   always @(posedge ref_clk_in) lvl <= tmoc_lvl_type'(7'($random(seed)));
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // read data and error are taken at the edge where pready is sampled high
   task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      psel <= 1'b1;
      pwrite <= is_wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_in);
      penable <= 1'b1;
      @(posedge ref_clk_in);
      while (pready !== 1'b1) @(posedge ref_clk_in);
      last_err = pslverr;
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge ref_clk_in);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic fire(input tmoc_evt_type ev);
      seen = 4'h0;
      @(posedge ref_clk_in);
      evt <= ev;
      for (int i = 0; i < 5; i++) begin
         @(posedge ref_clk_in);
         evt <= '0;
         @(negedge ref_clk_in);
         seen = seen | dma;
      end
   endtask

   function automatic logic [31:0] idle_exp(input logic [6:0] x);
      return {25'h0, x[5], x[3], x[1], x[6], x[4], x[2], x[0]};
   endfunction

   initial begin
      repeat (4) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      apb(1'b0, TMOC_OFF_CTL2, 32'h0);
      chk(q, TMOC_CTL2_RST);
      apb(1'b0, TMOC_OFF_SMCFG, 32'h0);
      chk(q, TMOC_SMCFG_RST);
      chk({31'h0, last_err}, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, last_err}, 32'h1);
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         wr(TMOC_OFF_CTL2, r & TMOC_CTL2_MASK);
         apb(1'b0, TMOC_OFF_CTL2, 32'h0);
         chk(q, r & TMOC_CTL2_MASK);
         wr(TMOC_OFF_SMCFG, r & TMOC_SMCFG_MASK);
         apb(1'b0, TMOC_OFF_SMCFG, 32'h0);
         chk(q, r & TMOC_SMCFG_MASK);
      end
      // write protection of idle bits
      wr(TMOC_OFF_CTL2, 32'h0);
      wr(TMOC_OFF_CTL, 32'h10);
      wr(TMOC_OFF_CTL2, 32'h7F10);
      apb(1'b0, TMOC_OFF_CTL2, 32'h0);
      chk(q, 32'h10);
      wr(TMOC_OFF_CTL, 32'h0);
      wr(TMOC_OFF_CTL2, 32'h0);
      repeat (12) @(posedge ref_clk_in);
      wr(TMOC_OFF_CTL2, 32'h100);
      @(negedge ref_clk_in);
      chk({31'h0, main[0]}, 32'h0);
      repeat (dead) @(negedge ref_clk_in);
      chk({31'h0, main[0]}, 32'h0);
      @(negedge ref_clk_in);
      chk({31'h0, main[0]}, 32'h1);
      for (int i = 0; i < 6; i++) begin
         v = 7'($random(seed));
         if (i == 0) v = 7'h7F;
         wr(TMOC_OFF_CTL2, {17'h0, v, 8'h00});
         repeat (12) @(posedge ref_clk_in);
         @(negedge ref_clk_in);
         chk({25'h0, comp, main}, idle_exp(v));
      end
      for (int i = 0; i < 8; i++) begin
         sel = i[0];
         wr(TMOC_OFF_CTL2, {24'h0, sel, 7'h0});
         @(posedge ref_clk_in);
         pins <= 3'($random(seed));
         repeat (3) @(posedge ref_clk_in);
         @(negedge ref_clk_in);
         chk({31'h0, trig_in}, {31'h0, sel ? ^pins : pins[0]});
      end
      for (int m = 0; m < 8; m++) begin
         wr(TMOC_OFF_CTL2, m << TMOC_B_MM_LO);
         base = cnt;
         e = '0;
         if (m == 3) e.ref_event = 4'hF;
         if (m > 3) e.cc_event = 4'hF;
         if (m > 3) e.ref_event = ~(4'h1 << (m - 4));
         if (m > 2) fire(e);
         e = '0;
         if (m == 0) wr(TMOC_OFF_EVENT, 32'h1);
         if (m == 1) wr(TMOC_OFF_CTL, 32'h0);
         if (m == 1) wr(TMOC_OFF_CTL, 32'h1);
         if (m == 2) e.overflow = 1'b1;
         if (m == 3) e.cc_event = 4'h1;
         if (m > 3) e.ref_event = 4'h1 << (m - 4);
         fire(e);
         chk({16'h0, cnt}, {16'h0, base + 16'h1});
      end
      wr(TMOC_OFF_CTL2, 32'h20);
      wr(TMOC_OFF_CTL, 32'h2);
      base = cnt;
      wr(TMOC_OFF_EVENT, 32'h1);
      repeat (4) @(posedge ref_clk_in);
      chk({16'h0, cnt}, {16'h0, base});
      wr(TMOC_OFF_CTL, 32'h4);
      wr(TMOC_OFF_EVENT, 32'h1);
      repeat (4) @(posedge ref_clk_in);
      chk({16'h0, cnt}, {16'h0, base});
      wr(TMOC_OFF_CTL, 32'h0);
      wr(TMOC_OFF_EVENT, 32'h1);
      repeat (4) @(posedge ref_clk_in);
      chk({16'h0, cnt}, {16'h0, base + 16'h1});
      wr(TMOC_OFF_CTL2, 32'h0);
      for (int k = 0; k < 4; k++) begin
         e = '0;
         e.cc_event = 4'h1 << k;
         fire(e);
         chk({28'h0, seen}, {28'h0, 4'h1 << k});
      end
      wr(TMOC_OFF_CTL2, 32'h8);
      e = '0;
      e.cc_event = 4'hF;
      fire(e);
      chk({28'h0, seen}, 32'h0);
      e = '0;
      e.overflow = 1'b1;
      fire(e);
      chk({28'h0, seen}, 32'hF);
      apb(1'b0, TMOC_OFF_STAT, 32'h0);
      chk({31'h0, q[TMOC_S_TRG]}, 32'h1);
      wr(TMOC_OFF_IRQEN, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(TMOC_OFF_IRQEN, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(TMOC_OFF_IRQCLR, 32'h1);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, TMOC_OFF_STAT, 32'h0);
      chk({31'h0, q[TMOC_S_TRG]}, 32'h0);
      // shadowed enables: ch3 main goes straight through
      wr(TMOC_OFF_CTL2, 32'h1);
      wr(TMOC_OFF_CHEN, 32'h7F);
      apb(1'b0, TMOC_OFF_CHEN, 32'h0);
      chk(q, 32'h8);
      wr(TMOC_OFF_EVENT, 32'h2);
      apb(1'b0, TMOC_OFF_CHEN, 32'h0);
      chk(q, 32'h7F);
      apb(1'b0, TMOC_OFF_STAT, 32'h0);
      chk({31'h0, q[TMOC_S_COM]}, 32'h1);
      // commutation on a trigger input rising edge
      @(posedge ref_clk_in);
      pins <= 3'h0;
      wr(TMOC_OFF_CTL2, 32'h5);
      wr(TMOC_OFF_CHEN, 32'h0);
      @(posedge ref_clk_in);
      pins <= 3'h1;
      repeat (3) @(posedge ref_clk_in);
      apb(1'b0, TMOC_OFF_CHEN, 32'h0);
      chk(q, 32'h0);
      chk({31'h0, long_pulse}, 32'h0);
      wrap_up();
   end
endmodule
